// ---- core/asr_host.sv ----
// Overview of operation
// - Read: select, output enable low, write high.
// - Either strobe rising ends the write.
// - Data setup, hold around terminating edge.
// - Host drives bus only when memory silent.
// - Address valid before chip select falls.
// - Write strobe stays high during reads.
`timescale 1ns/1ns
`default_nettype none
module asr_host
  import asr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [DATA_W-1:0] o_rdata,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_cs_n,
  output logic o_mem_we_n,
  output logic o_mem_oe_n,
  output logic [DATA_W-1:0] o_mem_dq,
  output logic o_mem_dq_oe_n,
  input wire logic [DATA_W-1:0] i_mem_dq
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETUP = 6'h02,
    ST_RD = 6'h04,
    ST_WR = 6'h08,
    ST_END = 6'h10,
    ST_TURN = 6'h20
  } asr_st_t;

  asr_st_t st_ff, nxt_st;
  logic wr_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff, dq_s1_ff, dq_s2_ff;
  logic rvalid_ff, cs_n_ff, we_n_ff, oe_n_ff, dq_oe_n_ff;

  asr_tmr_if tif ();
  asr_timer u_timer (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .tif(tif));

  wire logic accept = (st_ff == ST_IDLE) && i_req;
  wire logic rd_done = (st_ff == ST_RD) && tif.done;
  wire logic wr_done = (st_ff == ST_WR) && tif.done;
  assign o_ready = (st_ff == ST_IDLE);

  // Timer load: read access, write pulse, then bus turnaround for output disable time (T_HZOE_NS)
  assign tif.load = (st_ff == ST_SETUP) || (st_ff == ST_END);
  assign tif.count = (st_ff == ST_SETUP) ? (wr_ff ? CNT_W'(WR_PULSE_CYC - 1)
                                                  : CNT_W'(RD_WAIT_CYC - 1))
                                         : CNT_W'(TURN_CYC - 1);

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (i_req) nxt_st = ST_SETUP;
      ST_SETUP: nxt_st = wr_ff ? ST_WR : ST_RD;
      ST_RD: if (tif.done) nxt_st = ST_END;
      ST_WR: if (tif.done) nxt_st = ST_END;
      ST_END: nxt_st = ST_TURN;
      ST_TURN: if (tif.done) nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Strobe levels per state; address presented in SETUP before select falls
  wire logic nxt_cs_n = !((nxt_st == ST_RD) || (nxt_st == ST_WR));
  wire logic nxt_we_n = !(nxt_st == ST_WR);
  wire logic nxt_oe_n = !(nxt_st == ST_RD);
  // Data driven only during write pulse and the cycle after its end, for hold
  wire logic nxt_dq_oe_n = !((nxt_st == ST_WR) || (nxt_st == ST_END && wr_ff));

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= ST_IDLE;
      cs_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      dq_oe_n_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      cs_n_ff <= nxt_cs_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      dq_oe_n_ff <= nxt_dq_oe_n;
    end
  end

  // Address and data held for the whole access
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ff <= 1'b0;
      addr_ff <= ADDR_RST;
      wdata_ff <= DATA_RST;
    end else if (accept) begin
      wr_ff <= i_wr;
      addr_ff <= i_addr;
      wdata_ff <= i_wdata;
    end
  end

  // Bus pins come from outside; two stages before use
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      dq_s1_ff <= DATA_RST;
      dq_s2_ff <= DATA_RST;
    end else begin
      dq_s1_ff <= i_mem_dq;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // Sync delay is covered by one extra read cycle: sample after strobes drop
  logic cap_ff;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cap_ff <= 1'b0;
      rdata_ff <= DATA_RST;
      rvalid_ff <= 1'b0;
    end else begin
      cap_ff <= rd_done;
      rvalid_ff <= cap_ff;
      if (cap_ff) rdata_ff <= dq_s2_ff;
    end
  end

  assign o_mem_addr = addr_ff;
  assign o_mem_cs_n = cs_n_ff;
  assign o_mem_we_n = we_n_ff;
  assign o_mem_oe_n = oe_n_ff;
  assign o_mem_dq = wdata_ff;
  assign o_mem_dq_oe_n = dq_oe_n_ff;
  assign o_rdata = rdata_ff;
  assign o_rvalid = rvalid_ff;

  chk_rd_we_high: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !o_mem_oe_n |-> o_mem_we_n) else $error("write strobe low during read");
  chk_wr_oe_high: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !o_mem_we_n |-> o_mem_oe_n && !o_mem_cs_n) else $error("output enable low in write");
  chk_no_contend: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !o_mem_dq_oe_n |-> o_mem_oe_n) else $error("bus driven while memory may drive");
  chk_addr_stable: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !o_mem_cs_n && $past(!o_mem_cs_n) |-> $stable(o_mem_addr)) else $error("address moved");
  chk_addr_before: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $fell(o_mem_cs_n) |-> $stable(o_mem_addr)) else $error("address changed at select");
  chk_wr_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $fell(o_mem_we_n) |-> !o_mem_we_n [*2] ##1 o_mem_we_n) else $error("write pulse length");
  chk_data_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(o_mem_we_n) |-> !o_mem_dq_oe_n && $stable(o_mem_dq)) else $error("no data hold");
  chk_rd_length: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $fell(o_mem_oe_n) |-> !o_mem_oe_n [*4] ##1 o_mem_oe_n) else $error("read length");
  chk_rvalid_time: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(o_mem_oe_n) |-> ##1 o_rvalid) else $error("read data late");
  chk_cs_standby: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_mem_cs_n |-> o_mem_we_n && o_mem_oe_n) else $error("strobe active while deselected");
endmodule : asr_host
`default_nettype wire

// ---- core/asr_pkg.sv ----
package asr_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 20;
  // Access and write timing of the memory, in ns
  localparam int T_RC_NS = 45;
  localparam int T_AA_NS = 45;
  localparam int T_PWE_NS = 35;
  localparam int T_SD_NS = 25;
  localparam int T_HZOE_NS = 18;
  // Least times round up to whole cycles
  localparam int RD_WAIT_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WR_PULSE_CYC = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
endpackage : asr_pkg

// ---- core/asr_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module asr_timer
  import asr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  asr_tmr_if.tmr tif
);
  logic [CNT_W-1:0] cnt_ff;
  wire logic [CNT_W-1:0] nxt_cnt = tif.load ? tif.count :
                                   (cnt_ff != CNT_ZERO) ? cnt_ff - 4'h1 : CNT_ZERO;
  assign tif.done = (cnt_ff == CNT_ZERO) && !tif.load;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) cnt_ff <= CNT_ZERO;
    else cnt_ff <= nxt_cnt;
  end
endmodule : asr_timer
`default_nettype wire

// ---- core/asr_tmr_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface asr_tmr_if;
  import asr_pkg::*;
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : asr_tmr_if
`default_nettype wire

// ---- sim/asr_host_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module asr_host_test;
  import asr_pkg::*;
  logic clk, nrst, req, wr, ready, rvalid, cs_n, we_n, oe_n, dq_oe_n, drv;
  logic [ADDR_W-1:0] addr, maddr;
  logic [DATA_W-1:0] wdata, rdata, hdq, mdq, dq;
  logic [DATA_W-1:0] junk = 8'hA7;
  logic [ADDR_W-1:0] ta [3] = '{18'h00000, 18'h3FFFF, 18'h12345};
  logic [DATA_W-1:0] td [3] = '{8'hA5, 8'h5A, 8'h3C};
  int bad_count = 0;
  int n_compared = 0;
  // Nobody drives: a changing pattern, so a stale value cannot pass
  assign dq = !dq_oe_n ? hdq : drv ? mdq : junk;
  asr_host asr_host_i (.i_clk_sys(clk), .i_nrst(nrst), .i_req(req), .i_wr(wr),
    .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata),
    .o_mem_addr(maddr), .o_mem_cs_n(cs_n), .o_mem_we_n(we_n), .o_mem_oe_n(oe_n),
    .o_mem_dq(hdq), .o_mem_dq_oe_n(dq_oe_n), .i_mem_dq(dq));
  asr_sram_model asr_sram_model_i (.i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_addr(maddr), .i_dq(dq), .o_dq(mdq), .o_drv(drv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) junk <= junk + 8'h5B;
  task automatic chk_b(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk_b
  task automatic chk_d(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: read data %h, want %h", $time, got, exp);
    end
  endtask : chk_d
  always @(negedge clk) begin
    if (nrst && !cs_n) begin
      chk_b(drv && !dq_oe_n, 1'b0, "bus clash");
      chk_b(!we_n && !oe_n, 1'b0, "write and output enable together");
    end
  end
  task automatic go(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(negedge clk);
    while (ready !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk_b(ready, 1'b1, "ready never returned");
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
  endtask : go
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int k;
    go(1'b0, a, 8'h00);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (rvalid !== 1'b1 && k < 20);
    // Take edge, address set-up, strobed access, capture edge, then valid pulse
    chk_b(k == RD_WAIT_CYC + 3, 1'b1, "read latency");
    chk_d(rdata, e);
  endtask : rd
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    wrap_up();
  end
  initial begin
    nrst = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    addr = ADDR_RST;
    wdata = DATA_RST;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk_b(cs_n & we_n & oe_n & dq_oe_n, 1'b1, "idle strobes");
    chk_b(ready, 1'b1, "idle ready");
    for (int i = 0; i < 3; i++) go(1'b1, ta[i], td[i]);
    for (int i = 0; i < 3; i++) rd(ta[i], td[i]);
    go(1'b1, 18'h00000, 8'hFF);
    rd(18'h00000, 8'hFF);
    rd(18'h3FFFF, 8'h5A);
    wrap_up();
  end
endmodule : asr_host_test
`default_nettype wire

// ---- sim/asr_sram_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module asr_sram_model
  import asr_pkg::*;
(
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  output logic o_drv
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // Level write: the bus value at the closing strobe edge is what stays
  always @* begin
    if (!i_cs_n && !i_we_n) begin
      mem[i_addr] = i_dq;
    end
  end
  assign o_drv = !i_cs_n && i_we_n && !i_oe_n;
  assign o_dq = mem[i_addr];
endmodule : asr_sram_model
`default_nettype wire
